// ---- hdl/lsc_pkg.sv ----
// Constants shared by the low-power SDRAM command controller and its refresh timer
package lsc_pkg;
  // Address and data geometry
  localparam int ROW_W  = 13;
  localparam int COL_W  = 9;
  localparam int BANK_W = 2;
  localparam int DQ_W   = 16;
  localparam int MASK_W = 2;
  localparam int AP_BIT = 10;
  // Strobe patterns {row, column, write}, all active low, select low
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_BST  = 3'h6;
  localparam logic [2:0] CMD_NOP  = 3'h7;
  // Bank select codes during a mode-load cycle
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT  = 2'h2;
  // Mode and extended mode word field positions
  localparam int MR_BL_LSB   = 0;
  localparam int MR_WRAP_BIT = 3;
  localparam int MR_CL_LSB   = 4;
  localparam int EMR_PA_LSB  = 0;
  localparam int EMR_SRP_LSB = 3;
  // Read latency codes
  localparam logic [2:0] CL_CODE2 = 3'h2;
  localparam logic [2:0] CL_CODE3 = 3'h3;
  // Timing in ns and the derived cycle counts at the system clock
  localparam int CLK_NS     = 50;
  localparam int TRP_NS     = 20;
  localparam int TRCD_NS    = 20;
  localparam int TRFC_NS    = 80;
  localparam int TWR_NS     = 15;
  localparam int TMRD_CYC   = 2;
  localparam int INIT_NS    = 200000;
  localparam int INIT_REFS  = 2;
  localparam int TRP_CYC    = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRCD_CYC   = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRFC_CYC   = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWR_CYC    = (TWR_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_CYC   = (INIT_NS + CLK_NS - 1) / CLK_NS;
  // Refresh: rows per retention window, longest spacing rounds down
  localparam longint REF_WINDOW_NS = 64000000;
  localparam int     REF_ROWS      = 8192;
  localparam int     REF_CYC       = int'(REF_WINDOW_NS / (REF_ROWS * CLK_NS));
  localparam int     WAIT_W        = 12;
  // Controller states
  typedef enum logic [3:0] {
    ST_INIT_WAIT = 4'h0,
    ST_INIT_PALL = 4'h1,
    ST_INIT_REF  = 4'h2,
    ST_INIT_MRS  = 4'h3,
    ST_INIT_EXT_MODE_LOAD_CMD = 4'h4,
    ST_IDLE      = 4'h5,
    ST_ACT       = 4'h6,
    ST_RW        = 4'h7,
    ST_PRE       = 4'h8,
    ST_REF_PALL  = 4'h9,
    ST_REF       = 4'hA,
    ST_WAIT      = 4'hB,
    ST_PWRDN     = 4'hC,
    ST_SELFREF   = 4'hD,
    ST_DEEPPD    = 4'hE
  } lsc_state_t;
endpackage

// ---- hdl/lsc_refresh_timer.sv ----
// Refresh interval timer with a sticky refresh-owed flag
`timescale 1ns/1ps
module lsc_refresh_timer #(
  parameter int INTERVAL = lsc_pkg::REF_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Refresh handshake
  input  wire logic served,
  output logic      due
);
  import lsc_pkg::*;

  logic [15:0] count;
  wire         tick = (count == 16'(INTERVAL - 1));

  // Free-running interval counter
  always_ff @(posedge clock) begin
    if (!rst_n || tick) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // A new tick in the serving cycle wins, so no refresh slot is lost
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      due <= 1'b0;
    end else if (tick) begin
      due <= 1'b1;
    end else if (served) begin
      due <= 1'b0;
    end
  end
endmodule

// ---- hdl/lsc_ctrl.sv ----
// Host-side command controller for a four-bank low-power SDRAM
// How it works
// - Pins registered, valid at device rising edge
// - Clock gate low for power-down, self-refresh
// - Command from row/column/write strobes plus select
// - Bank select names target bank
// - Bank select picks mode or extended mode
// - Activate drives full 13-bit row
// - Column on nine lowest address bits
// - Read latency two or three cycles
// - Column commands may follow back to back; this controller issues one per activate
// - 8192 auto-refreshes every 64 ms
`timescale 1ns/1ps
module lsc_ctrl #(
  parameter int INIT_CYCLES = lsc_pkg::INIT_CYC,
  parameter int REF_CYCLES  = lsc_pkg::REF_CYC
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // User request port
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic                        req_auto_pre,
  input  wire logic [lsc_pkg::BANK_W-1:0]  req_bank,
  input  wire logic [lsc_pkg::ROW_W-1:0]   req_row,
  input  wire logic [lsc_pkg::COL_W-1:0]   req_col,
  input  wire logic [lsc_pkg::DQ_W-1:0]    req_wdata,
  input  wire logic [lsc_pkg::MASK_W-1:0]  req_mask,
  // Read return
  output logic                             rd_valid,
  output logic [lsc_pkg::DQ_W-1:0]         rd_data,
  // Configuration and power requests
  input  wire logic                        cfg_latency3,
  input  wire logic [2:0]                  cfg_burst_code,
  input  wire logic                        cfg_interleave,
  input  wire logic [2:0]                  cfg_sr_array,
  input  wire logic [1:0]                  cfg_sr_period,
  input  wire logic                        cfg_reload,
  input  wire logic                        pd_req,
  input  wire logic                        sr_req,
  input  wire logic                        dpd_req,
  output logic                             init_done,
  // Device pins
  output logic                             mem_cke,
  output logic                             mem_sel_n,
  output logic                             mem_row_n,
  output logic                             mem_col_n,
  output logic                             mem_wr_n,
  output logic                             bank_select_lo,
  output logic                             bank_select_hi,
  output logic [lsc_pkg::ROW_W-1:0]        mem_addr,
  output logic [lsc_pkg::MASK_W-1:0]       byte_mask,
  output logic [lsc_pkg::DQ_W-1:0]         dq_out,
  output logic                             dq_oe,
  input  wire logic [lsc_pkg::DQ_W-1:0]    dq_in
);
  import lsc_pkg::*;

  lsc_state_t          state, next_state, ret, next_ret;
  logic [WAIT_W-1:0]   wait_cnt, next_wait;
  logic [1:0]          refs, next_refs;
  logic [2:0]          next_cmd;
  logic                next_sel_n, next_cke, take, served;
  logic [ROW_W-1:0]    next_addr;
  logic [BANK_W-1:0]   next_bank, bank_q;
  logic [ROW_W-1:0]    row_q;
  logic [COL_W-1:0]    col_q;
  logic [DQ_W-1:0]     wdata_q;
  logic [MASK_W-1:0]   mask_q;
  logic                wr_q, ap_q, cl3_q;
  logic [2:0]          rd_pipe;
  logic                refresh_due;

  // Mode words built from the configuration inputs
  wire [ROW_W-1:0] mode_word = ROW_W'({cfg_latency3 ? CL_CODE3 : CL_CODE2, cfg_interleave,
                                       cfg_burst_code});
  wire [ROW_W-1:0] ext_word  = ROW_W'({cfg_sr_period, cfg_sr_array});
  wire [ROW_W-1:0] ap_all    = ROW_W'(1) << AP_BIT;
  wire [ROW_W-1:0] col_word  = ROW_W'(col_q) | (ap_q ? ap_all : '0);
  wire [2:0]       pin_cmd   = {mem_row_n, mem_col_n, mem_wr_n};
  wire             pin_act   = !mem_sel_n && pin_cmd == CMD_ACT;
  wire             pin_rd    = !mem_sel_n && pin_cmd == CMD_RD;
  wire             pin_wr    = !mem_sel_n && pin_cmd == CMD_WR;
  wire             pin_pre   = !mem_sel_n && pin_cmd == CMD_PRE;
  wire             pin_ref   = !mem_sel_n && pin_cmd == CMD_REF;
  wire             wr_cycle  = (state == ST_RW) && wr_q;
  wire [WAIT_W-1:0] w_trp    = WAIT_W'(TRP_CYC - 1);
  wire [WAIT_W-1:0] w_trfc   = WAIT_W'(TRFC_CYC - 1);

  // Refresh slots at one per retention window divided by row count
  lsc_refresh_timer #(.INTERVAL(REF_CYCLES)) u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .served (served),
    .due    (refresh_due)
  );

  // Idle only; power and refresh requests take priority over traffic
  assign req_ready = (state == ST_IDLE) && !refresh_due && !cfg_reload
                     && !dpd_req && !sr_req && !pd_req;
  assign take      = req_valid && req_ready;

  // Sequencer: each command cycle except self-refresh or deep power-down entry loads a wait, then falls to the return state
  always_comb begin
    next_state = state;
    next_ret   = ret;
    next_wait  = wait_cnt;
    next_refs  = refs;
    next_cmd   = CMD_NOP;
    next_sel_n = 1'b0;
    next_cke   = 1'b1;
    next_addr  = mem_addr;
    next_bank  = {bank_select_hi, bank_select_lo};
    served     = 1'b0;
    unique case (state)
      ST_INIT_WAIT: begin
        if (wait_cnt == '0) next_state = ST_INIT_PALL;
        else next_wait = wait_cnt - 1'b1;
      end
      ST_INIT_PALL: begin
        next_cmd = CMD_PRE; next_addr = ap_all; next_wait = w_trp;
        next_refs = 2'(INIT_REFS); next_ret = ST_INIT_REF; next_state = ST_WAIT;
      end
      ST_INIT_REF: begin
        next_cmd = CMD_REF; next_wait = w_trfc; next_refs = refs - 1'b1;
        next_ret = (refs == 2'h1) ? ST_INIT_MRS : ST_INIT_REF; next_state = ST_WAIT;
      end
      ST_INIT_MRS: begin
        next_cmd = CMD_MODE; next_bank = BANK_MODE; next_addr = mode_word;
        next_wait = WAIT_W'(TMRD_CYC - 1); next_ret = ST_INIT_EXT_MODE_LOAD_CMD; next_state = ST_WAIT;
      end
      ST_INIT_EXT_MODE_LOAD_CMD: begin
        next_cmd = CMD_MODE; next_bank = BANK_EXT; next_addr = ext_word;
        next_wait = WAIT_W'(TMRD_CYC - 1); next_ret = ST_IDLE; next_state = ST_WAIT;
      end
      ST_IDLE: begin
        if (refresh_due) next_state = ST_REF_PALL;
        else if (cfg_reload) next_state = ST_INIT_MRS;
        else if (dpd_req) begin
          next_cmd = CMD_BST; next_cke = 1'b0; next_state = ST_DEEPPD;
        end else if (sr_req) begin
          next_cmd = CMD_REF; next_cke = 1'b0; next_state = ST_SELFREF;
        end else if (pd_req) begin
          next_cke = 1'b0; next_state = ST_PWRDN;
        end else if (take) next_state = ST_ACT;
      end
      ST_ACT: begin
        next_cmd = CMD_ACT; next_bank = bank_q; next_addr = row_q;
        next_wait = WAIT_W'(TRCD_CYC - 1); next_ret = ST_RW; next_state = ST_WAIT;
      end
      ST_RW: begin
        next_cmd = wr_q ? CMD_WR : CMD_RD; next_bank = bank_q; next_addr = col_word;
        next_wait = ap_q ? WAIT_W'(TWR_CYC + TRP_CYC - 1) : WAIT_W'(TWR_CYC - 1);
        next_ret = ap_q ? ST_IDLE : ST_PRE; next_state = ST_WAIT;
      end
      ST_PRE: begin
        next_cmd = CMD_PRE; next_bank = bank_q; next_addr = '0;
        next_wait = w_trp; next_ret = ST_IDLE; next_state = ST_WAIT;
      end
      ST_REF_PALL: begin
        next_cmd = CMD_PRE; next_addr = ap_all;
        next_wait = w_trp; next_ret = ST_REF; next_state = ST_WAIT;
      end
      ST_REF: begin
        next_cmd = CMD_REF; served = 1'b1;
        next_wait = w_trfc; next_ret = ST_IDLE; next_state = ST_WAIT;
      end
      ST_WAIT: begin
        next_sel_n = 1'b1;
        if (wait_cnt == '0) next_state = ret;
        else next_wait = wait_cnt - 1'b1;
      end
      ST_PWRDN: begin
        // Leave power-down for a pending refresh so the schedule holds
        next_cke = 1'b0;
        if (!pd_req || refresh_due) begin
          next_cke = 1'b1; next_state = ST_IDLE;
        end
      end
      ST_SELFREF: begin
        next_cke = 1'b0;
        if (!sr_req) begin
          next_cke = 1'b1; next_wait = w_trfc; next_ret = ST_IDLE; next_state = ST_WAIT;
        end
      end
      ST_DEEPPD: begin
        // Array contents are lost, so leaving runs the full power-up again
        next_cke = 1'b0;
        if (!dpd_req) begin
          next_cke = 1'b1; next_wait = WAIT_W'(INIT_CYCLES - 1);
          next_state = ST_INIT_WAIT;
        end
      end
      default: next_state = ST_INIT_WAIT;
    endcase
  end

  // State, waits and the latched request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_INIT_WAIT;
      ret <= ST_IDLE;
      wait_cnt <= WAIT_W'(INIT_CYCLES - 1);
      refs <= 2'h0;
    end else begin
      state <= next_state;
      ret <= next_ret;
      wait_cnt <= next_wait;
      refs <= next_refs;
    end
  end

  always_ff @(posedge clock) begin
    if (take) begin
      {wr_q, ap_q, bank_q, row_q} <= {req_write, req_auto_pre, req_bank, req_row};
      {col_q, wdata_q, mask_q} <= {req_col, req_wdata, req_mask};
    end
  end

  // Pins come from flip-flops, stable across the device's sampling edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {mem_cke, mem_sel_n} <= 2'h1;
      {mem_row_n, mem_col_n, mem_wr_n} <= CMD_NOP;
      {bank_select_hi, bank_select_lo, mem_addr} <= '0;
      {byte_mask, dq_out, dq_oe} <= '0;
      cl3_q <= 1'b0;
    end else begin
      mem_cke <= next_cke;
      mem_sel_n <= next_sel_n;
      {mem_row_n, mem_col_n, mem_wr_n} <= next_cmd;
      {bank_select_hi, bank_select_lo} <= next_bank;
      mem_addr <= next_addr;
      byte_mask <= (state == ST_RW) ? mask_q : '0;
      dq_out <= wdata_q;
      dq_oe <= wr_cycle;
      if (state == ST_INIT_MRS) cl3_q <= cfg_latency3;
    end
  end

  // Read data captured after the programmed latency; commands may stream
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_pipe <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      init_done <= 1'b0;
    end else begin
      rd_pipe <= {rd_pipe[1:0], pin_rd};
      rd_valid <= cl3_q ? rd_pipe[2] : rd_pipe[1];
      if (cl3_q ? rd_pipe[2] : rd_pipe[1]) rd_data <= dq_in;
      if (state == ST_IDLE) init_done <= 1'b1;
      else if (state == ST_INIT_WAIT) init_done <= 1'b0;
    end
  end

  read_lat2_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_rd && !cl3_q |-> ##3 rd_valid) else $error("latency 2 read slip");
  read_lat3_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_rd && cl3_q |-> !rd_valid ##4 rd_valid) else $error("latency 3 read slip");
  act_row_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_act |-> mem_addr == row_q && next_bank == bank_q)
    else $error("activate row or bank wrong");
  col_ap_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_rd || pin_wr |-> mem_addr[COL_W-1:0] == col_q && mem_addr[AP_BIT] == ap_q)
    else $error("column or precharge flag wrong");
  pre_one_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_pre && !mem_addr[AP_BIT] |-> {bank_select_hi, bank_select_lo} == bank_q)
    else $error("single precharge bank wrong");
  // Power-up issues its refreshes back to back after a single precharge-all
  ref_pall_a: assert property (@(posedge clock) disable iff (!rst_n)
    pin_ref && mem_cke |-> ($past(pin_pre, TRP_CYC + 1) && $past(mem_addr[AP_BIT], TRP_CYC + 1))
                           || $past(pin_ref, TRFC_CYC + 1))
    else $error("refresh without precharge all");
  req_act_a: assert property (@(posedge clock) disable iff (!rst_n)
    take |-> ##2 pin_act) else $error("accepted request not activated");
  wr_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    dq_oe |-> pin_wr) else $error("data driven without write");
  due_ref_a: assert property (@(posedge clock) disable iff (!rst_n)
    refresh_due && state == ST_IDLE |-> ##[1:6] pin_ref) else $error("refresh late");
endmodule

// ---- dv/lsc_sdram_model.sv ----
// Behavioural four-bank low-power SDRAM facing the command controller
`timescale 1ns/1ps
module lsc_sdram_model (
  // Clock and command pins
  input  wire logic                       clock,
  input  wire logic                       mem_cke,
  input  wire logic                       mem_sel_n,
  input  wire logic                       mem_row_n,
  input  wire logic                       mem_col_n,
  input  wire logic                       mem_wr_n,
  input  wire logic                       bank_select_lo,
  input  wire logic                       bank_select_hi,
  input  wire logic [lsc_pkg::ROW_W-1:0]  mem_addr,
  // Data pins
  input  wire logic [lsc_pkg::MASK_W-1:0] byte_mask,
  input  wire logic [lsc_pkg::DQ_W-1:0]   dq_out,
  input  wire logic                       dq_oe,
  output logic      [lsc_pkg::DQ_W-1:0]   dq_in,
  // Observation for the bench
  output logic      [3:0]                 open_mask,
  output logic      [12:0]                mode_word,
  output logic      [12:0]                ext_word,
  output int                              viol,
  output int                              n_ref,
  output int                              n_sr,
  output int                              n_dpd
);
  import lsc_pkg::*;
  logic [DQ_W-1:0]  mem [int];
  logic [ROW_W-1:0] row_q [4];
  logic [DQ_W-1:0]  pd [3];
  logic [DQ_W-1:0]  last_q, w;
  logic [2:0]       pv;
  logic [1:0]       b;
  logic             cke_q, hit;
  int               k, lat;
  // Bank and latency decode
  assign b   = {bank_select_hi, bank_select_lo};
  assign lat = (mode_word[MR_CL_LSB +: 3] == CL_CODE3) ? 3 : 2;
  // A released bus shows the inverse of the last word, so a stale capture never matches
  assign dq_in = pv[lat-1] ? pd[lat-1] : ~last_q;
  initial begin
    {open_mask, mode_word, ext_word, cke_q, pv, last_q} = '0;
    {viol, n_ref, n_sr, n_dpd} = '0;
  end
  // Pins count only at the rising edge and only while the clock was enabled
  always @(posedge clock) begin
    hit = 1'b0;
    k   = int'({b, row_q[b], mem_addr[COL_W-1:0]});
    if (!mem_sel_n && cke_q) begin
      case ({mem_row_n, mem_col_n, mem_wr_n})
        CMD_ACT: begin
          if (open_mask[b]) viol++;
          open_mask[b] = 1'b1;
          row_q[b]     = mem_addr;
        end
        CMD_RD, CMD_WR: begin
          if (!open_mask[b] || (!mem_wr_n && !dq_oe)) viol++;
          w = mem.exists(k) ? mem[k] : 16'h5A5A;
          for (int i = 0; i < MASK_W; i++) begin
            if (!mem_wr_n && !byte_mask[i]) w[i*8 +: 8] = dq_out[i*8 +: 8];
            if (mem_wr_n && byte_mask[i]) w[i*8 +: 8] = ~w[i*8 +: 8];
          end
          if (!mem_wr_n) mem[k] = w;
          hit = mem_wr_n;
          if (mem_addr[AP_BIT]) open_mask[b] = 1'b0;
        end
        CMD_PRE: begin
          if (mem_addr[AP_BIT]) open_mask = 4'h0;
          else open_mask[b] = 1'b0;
        end
        CMD_REF: begin
          if (open_mask != 4'h0) viol++;
          if (mem_cke) n_ref++;
          else n_sr++;
        end
        CMD_MODE: begin
          if (b == BANK_MODE) mode_word <= mem_addr;
          else if (b == BANK_EXT) ext_word <= mem_addr;
          else viol++;
        end
        CMD_BST: if (!mem_cke) n_dpd++;
        default: ;
      endcase
    end
    // Read data walks a short pipe so either latency can be served
    cke_q <= mem_cke;
    pv    <= {pv[1:0], hit};
    pd[0] <= w;
    pd[1] <= pd[0];
    pd[2] <= pd[1];
    if (pv[lat-1]) last_q <= pd[lat-1];
  end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the SDRAM command controller against a behavioural device
`timescale 1ns/1ps
module tb;
  import lsc_pkg::*;
  logic             clock, rst_n, req_valid, req_ready, req_write, req_auto_pre, rd_valid;
  logic             cfg_latency3, cfg_interleave, cfg_reload, pd_req, sr_req, dpd_req;
  logic             init_done, mem_cke, mem_sel_n, mem_row_n, mem_col_n, mem_wr_n, dq_oe;
  logic             bank_select_lo, bank_select_hi;
  logic [1:0]       req_bank, req_mask, cfg_sr_period, byte_mask;
  logic [2:0]       cfg_burst_code, cfg_sr_array;
  logic [ROW_W-1:0] req_row, mem_addr;
  logic [COL_W-1:0] req_col;
  logic [DQ_W-1:0]  req_wdata, rd_data, dq_out, dq_in, q;
  logic [3:0]       open_mask;
  logic [12:0]      mode_word, ext_word;
  int               viol, n_ref, n_sr, n_dpd, n_fail, samples_checked, lat;
  lsc_ctrl #(.INIT_CYCLES(8), .REF_CYCLES(40)) lsc_ctrl_inst (
    .clock, .rst_n, .req_valid, .req_ready, .req_write, .req_auto_pre, .req_bank, .req_row,
    .req_col, .req_wdata, .req_mask, .rd_valid, .rd_data, .cfg_latency3, .cfg_burst_code,
    .cfg_interleave, .cfg_sr_array, .cfg_sr_period, .cfg_reload, .pd_req, .sr_req, .dpd_req,
    .init_done, .mem_cke, .mem_sel_n, .mem_row_n, .mem_col_n, .mem_wr_n, .bank_select_lo,
    .bank_select_hi, .mem_addr, .byte_mask, .dq_out, .dq_oe, .dq_in
  );
  lsc_sdram_model lsc_sdram_model_inst (
    .clock, .mem_cke, .mem_sel_n, .mem_row_n, .mem_col_n, .mem_wr_n, .bank_select_lo,
    .bank_select_hi, .mem_addr, .byte_mask, .dq_out, .dq_oe, .dq_in, .open_mask, .mode_word,
    .ext_word, .viol, .n_ref, .n_sr, .n_dpd
  );
  // 20 MHz system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Expected mode word: latency code, wrap bit, burst code
  function automatic logic [15:0] mw(input logic l3, input logic [2:0] bc, input logic il);
    return 16'({l3 ? CL_CODE3 : CL_CODE2, il, bc});
  endfunction
  // Bounded wait at falling edges; ready seen here is what the next rising edge samples
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk("req_ready", 16'h1, {15'h0, req_ready});
  endtask
  task automatic wait_cke_low(input string what);
    int n;
    n = 0;
    while (mem_cke !== 1'b0 && n < 30) begin
      @(negedge clock);
      n++;
    end
    chk(what, 16'h0, {15'h0, mem_cke});
  endtask
  // One request held until taken; a read also counts cycles to its answer
  task automatic xfer(input logic w, ap, input logic [1:0] b, input logic [12:0] r,
                      input logic [8:0] c, input logic [15:0] d, input logic [1:0] m);
    @(negedge clock);
    {req_write, req_auto_pre, req_bank, req_row, req_col, req_wdata, req_mask} =
      {w, ap, b, r, c, d, m};
    req_valid = 1'b1;
    wait_ready(300);
    @(negedge clock);
    req_valid = 1'b0;
    lat = 1;
    while (!w && rd_valid !== 1'b1 && lat < 30) begin
      @(negedge clock);
      lat++;
    end
    q = rd_data;
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] r, input logic [8:0] c,
                    input logic [15:0] exp, input int el);
    xfer(1'b0, 1'b0, b, r, c, 16'h0, 2'h0);
    chk("rd_data", exp, q);
    chk("rd_latency", 16'(el), 16'(lat));
  endtask
  // Reload is held a few cycles so a refresh in progress cannot swallow it
  task automatic reload(input logic l3, input logic [2:0] bc, input logic il);
    {cfg_latency3, cfg_burst_code, cfg_interleave, cfg_reload} = {l3, bc, il, 1'b1};
    repeat (8) @(negedge clock);
    cfg_reload = 1'b0;
    wait_ready(40);
    chk("mode_word", mw(l3, bc, il), {3'h0, mode_word});
  endtask
  task automatic test_init;
    wait_ready(200);
    // The done flag is registered one edge after the sequencer reaches idle
    @(negedge clock);
    chk("init_done", 16'h1, {15'h0, init_done});
    chk("init_refreshes", 16'h1, 16'(n_ref >= INIT_REFS));
    chk("mode_word", mw(1'b0, 3'h0, 1'b1), {3'h0, mode_word});
    chk("ext_word", 16'({cfg_sr_period, cfg_sr_array}), {3'h0, ext_word});
    $display("test init done");
  endtask
  task automatic test_banks;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, i[0], 2'(i), 13'h1FFF - 13'(i), 9'h1FF - 9'(i), 16'hA500 | 16'(i), 2'h0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), 13'h1FFF - 13'(i), 9'h1FF - 9'(i), 16'hA500 | 16'(i), 7);
    end
    chk("open_mask", 16'h0, {12'h0, open_mask});
    $display("test banks done");
  endtask
  task automatic test_mask;
    xfer(1'b1, 1'b0, 2'h1, 13'h0005, 9'h003, 16'h1234, 2'h0);
    xfer(1'b1, 1'b0, 2'h1, 13'h0005, 9'h003, 16'hABCD, 2'h1);
    rd(2'h1, 13'h0005, 9'h003, 16'hAB34, 7);
    $display("test mask done");
  endtask
  task automatic test_latency;
    logic [2:0] codes [4];
    codes = '{3'h1, 3'h2, 3'h3, 3'h7};
    reload(1'b1, 3'h0, 1'b0);
    rd(2'h1, 13'h0005, 9'h003, 16'hAB34, 8);
    foreach (codes[i]) reload(1'b0, codes[i], 1'b1);
    reload(1'b0, 3'h0, 1'b1);
    rd(2'h1, 13'h0005, 9'h003, 16'hAB34, 7);
    $display("test latency done");
  endtask
  task automatic test_refresh;
    int r0;
    r0 = n_ref;
    repeat (400) @(negedge clock);
    chk("refresh_count", 16'h1, 16'((n_ref - r0) >= 9 && (n_ref - r0) <= 11));
    $display("test refresh done");
  endtask
  task automatic test_power;
    int s0;
    pd_req = 1'b1;
    wait_cke_low("cke_power_down");
    pd_req = 1'b0;
    wait_ready(60);
    s0 = n_sr;
    sr_req = 1'b1;
    wait_cke_low("cke_self_refresh");
    repeat (20) @(negedge clock);
    chk("cke_held", 16'h0, {15'h0, mem_cke});
    chk("self_refresh", 16'(s0 + 1), 16'(n_sr));
    sr_req = 1'b0;
    rd(2'h1, 13'h0005, 9'h003, 16'hAB34, 7);
    s0 = n_dpd;
    dpd_req = 1'b1;
    wait_cke_low("cke_deep");
    repeat (5) @(negedge clock);
    chk("deep_power_down", 16'(s0 + 1), 16'(n_dpd));
    dpd_req = 1'b0;
    wait_ready(200);
    xfer(1'b1, 1'b1, 2'h2, 13'h0A5A, 9'h0A5, 16'h5AA5, 2'h0);
    rd(2'h2, 13'h0A5A, 9'h0A5, 16'h5AA5, 7);
    chk("violations", 16'h0, 16'(viol));
    $display("test power done");
  endtask
  // Main sequence: reset, then each scenario in turn
  initial begin
    {rst_n, req_valid, req_write, req_auto_pre, req_bank, req_row, req_col} = '0;
    {req_wdata, req_mask, cfg_latency3, cfg_reload, pd_req, sr_req, dpd_req} = '0;
    {cfg_burst_code, cfg_interleave, cfg_sr_array, cfg_sr_period} = {3'h0, 1'b1, 3'h5, 2'h2};
    {n_fail, samples_checked} = '0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    test_init();
    test_banks();
    test_mask();
    test_latency();
    test_refresh();
    test_power();
    final_report();
  end
  // Watchdog: the scenarios need well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    final_report();
  end
endmodule
